// ===== logic/e1_rx_alarm_irq_pkg.sv
// Package for the receive E1 alarm interrupt block: register map, field positions, reset values.
// Assumes a 32-bit classic Wishbone register bus with byte addresses and 8-bit registers in the low lane.
package e1_rx_alarm_irq_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int unsigned WB_ADR_W = 8;
    localparam int unsigned WB_DAT_W = 32;
    localparam int unsigned WB_SEL_W = 4;
    localparam int unsigned REG_W = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [WB_ADR_W-1:0] EXCESS_ZERO_CHANGE_FLAG_OFS = 8'h00;
    localparam logic [WB_ADR_W-1:0] EXZ_ENABLE_OFS = 8'h04;
    localparam logic [WB_ADR_W-1:0] LOS_CRC_STATUS_OFS = 8'h08;
    localparam logic [WB_ADR_W-1:0] LOS_CRC_ENABLE_OFS = 8'h0C;

    ////////////////////////////////////////////////////////////////////////////
    // Excessive-zero status / enable fields
    localparam int unsigned EXZ_FLAG_BIT = 0;
    localparam int unsigned NATBIT7_FLAG_BIT = 1;
    localparam int unsigned NATBIT7_STATE_BIT = 5;
    localparam int unsigned EXZ_EN_BIT = 0;
    localparam int unsigned NATBIT7_EN_BIT = 1;

    // Loss/CRC status / enable fields
    localparam int unsigned TS16_STATE_BIT = 4;
    localparam int unsigned LOS_FLAG_BIT = 3;
    localparam int unsigned CRC_FLAG_BIT = 2;
    localparam int unsigned LOS_EN_BIT = 3;
    localparam int unsigned CRC_EN_BIT = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [REG_W-1:0] EXZ_ENABLE_RST = 8'h00;
    localparam logic [REG_W-1:0] LOS_CRC_ENABLE_RST = 8'h00;
    localparam logic FLAG_RST = 1'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Sa7 qualification: zero seen in at least VOTE_MIN of the last VOTE_WIN observations
    localparam int unsigned VOTE_WIN = 3;
    localparam int unsigned VOTE_MIN = 2;
    localparam logic [VOTE_WIN-1:0] VOTE_HIST_RST = 3'h0;

endpackage : e1_rx_alarm_irq_pkg

// ===== logic/alarm_change_detect.sv
// Change detector: one-cycle pulse whenever a level alarm changes state.
// Assumes the level is synchronous to the clock; the first sampled value after reset is taken silently.
`timescale 1ns/1ps
`default_nettype none

module alarm_change_detect
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Alarm level in, change pulse out
    input wire logic i_level,
    output logic o_change
);

    logic prev_ff;
    logic primed_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Remember the last level; no event at the first sample, so a standing alarm at reset raises nothing
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            prev_ff <= 1'b0;
            primed_ff <= 1'b0;
        end
        else
        begin
            prev_ff <= i_level;
            primed_ff <= 1'b1;
        end
    end

    // Both directions count: entry and exit each give one pulse
    assign o_change = primed_ff & (prev_ff ^ i_level);

endmodule : alarm_change_detect

`default_nettype wire

// ===== logic/e1_rx_alarm_irq_logic.sv
// Receive E1 alarm interrupt block: change flags, enables, state bits and one interrupt line.
// Assumes alarm levels and the Sa7 observation strobe are synchronous to I_CLK_SYS (25 MHz).
`timescale 1ns/1ps
`default_nettype none

module e1_rx_alarm_irq_logic
(
    // System clock and synchronous reset
    input wire logic I_CLK_SYS,
    input wire logic I_RESET,
    // Wishbone classic slave
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [e1_rx_alarm_irq_pkg::WB_ADR_W-1:0] I_WB_ADR,
    input wire logic [e1_rx_alarm_irq_pkg::WB_SEL_W-1:0] I_WB_SEL,
    input wire logic [e1_rx_alarm_irq_pkg::WB_DAT_W-1:0] I_WB_DAT,
    output logic [e1_rx_alarm_irq_pkg::WB_DAT_W-1:0] O_WB_DAT,
    output logic O_WB_ACK,
    // Receive framer alarm inputs
    input wire logic I_NATBIT7,
    input wire logic I_NATBIT7_VALID,
    input wire logic I_EXCESS_ZERO,
    input wire logic I_LOSS_SIGNAL,
    input wire logic I_CRC_MFRAME_LOCK,
    input wire logic I_TS16_ALL_ONES,
    // Interrupt request, active high level
    output logic O_IRQ
);

    import e1_rx_alarm_irq_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [VOTE_WIN-1:0] sa7_hist_ff;
    logic [VOTE_WIN-1:0] nxt_sa7_hist;
    logic natbit7_zero_ff;
    logic nxt_natbit7_zero;
    logic [1:0] zero_votes;

    logic natbit7_zero_change;
    logic excess_zero_change;
    logic loss_signal_change;
    logic crc_mframe_change;

    logic natbit7_zero_change_flag_ff;
    logic excess_zero_change_flag_ff;
    logic loss_signal_change_flag_ff;
    logic crc_mframe_change_flag_ff;

    logic [REG_W-1:0] excess_zero_irq_enable_ff;
    logic [REG_W-1:0] los_crc_irq_enable_ff;
    logic ts16_all_ones_state_ff;

    logic natbit7_zero_change_irq_en;
    logic excess_zero_change_irq_en;
    logic loss_signal_change_irq_en;
    logic crc_mframe_change_irq_en;

    logic wb_req;
    logic wb_wr;
    logic wb_rd;
    logic rd_clear_exz;
    logic rd_clear_los_crc;
    logic [REG_W-1:0] excess_zero_irq_status;
    logic [REG_W-1:0] los_crc_irq_status;
    logic [WB_DAT_W-1:0] nxt_rd_data;

    logic wb_ack_ff;
    logic [WB_DAT_W-1:0] wb_dat_ff;
    logic irq_ff;
    logic nxt_irq;

    ////////////////////////////////////////////////////////////////////////////
    // Sa7 two-of-three qualification
    always_comb
    begin
        nxt_sa7_hist = sa7_hist_ff;
        if (I_NATBIT7_VALID)
        begin
            nxt_sa7_hist = {sa7_hist_ff[VOTE_WIN-2:0], ~I_NATBIT7};
        end
    end

    assign zero_votes = 2'(sa7_hist_ff[0]) + 2'(sa7_hist_ff[1]) + 2'(sa7_hist_ff[2]);
    assign nxt_natbit7_zero = (zero_votes >= 2'(VOTE_MIN));

    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RESET)
        begin
            sa7_hist_ff <= VOTE_HIST_RST;
            natbit7_zero_ff <= 1'b0;
        end
        else
        begin
            sa7_hist_ff <= nxt_sa7_hist;
            natbit7_zero_ff <= nxt_natbit7_zero;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Change detection, one instance per alarm except time slot 16, which has no change flag
    alarm_change_detect u_natbit7_chg
    (
        .i_clk(I_CLK_SYS),
        .i_reset(I_RESET),
        .i_level(natbit7_zero_ff),
        .o_change(natbit7_zero_change)
    );

    alarm_change_detect u_excess_zero_chg
    (
        .i_clk(I_CLK_SYS),
        .i_reset(I_RESET),
        .i_level(I_EXCESS_ZERO),
        .o_change(excess_zero_change)
    );

    alarm_change_detect u_loss_signal_chg
    (
        .i_clk(I_CLK_SYS),
        .i_reset(I_RESET),
        .i_level(I_LOSS_SIGNAL),
        .o_change(loss_signal_change)
    );

    alarm_change_detect u_crc_mframe_chg
    (
        .i_clk(I_CLK_SYS),
        .i_reset(I_RESET),
        .i_level(I_CRC_MFRAME_LOCK),
        .o_change(crc_mframe_change)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode: one access per request, answered with ack in the next cycle
    assign wb_req = I_WB_CYC & I_WB_STB & ~wb_ack_ff;
    assign wb_wr = wb_req & I_WB_WE & I_WB_SEL[0];
    assign wb_rd = wb_req & ~I_WB_WE;
    assign rd_clear_exz = wb_rd & (I_WB_ADR == EXCESS_ZERO_CHANGE_FLAG_OFS);
    assign rd_clear_los_crc = wb_rd & (I_WB_ADR == LOS_CRC_STATUS_OFS);

    ////////////////////////////////////////////////////////////////////////////
    // Sticky change flags; an event in the clearing cycle wins over the clear
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RESET)
        begin
            excess_zero_change_flag_ff <= FLAG_RST;
            natbit7_zero_change_flag_ff <= FLAG_RST;
            loss_signal_change_flag_ff <= FLAG_RST;
            crc_mframe_change_flag_ff <= FLAG_RST;
        end
        else
        begin
            excess_zero_change_flag_ff <= (excess_zero_change_flag_ff & ~rd_clear_exz) | excess_zero_change;
            natbit7_zero_change_flag_ff <= (natbit7_zero_change_flag_ff & ~rd_clear_exz) | natbit7_zero_change;
            loss_signal_change_flag_ff <= (loss_signal_change_flag_ff & ~rd_clear_los_crc) | loss_signal_change;
            crc_mframe_change_flag_ff <= (crc_mframe_change_flag_ff & ~rd_clear_los_crc) | crc_mframe_change;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Live time slot 16 state, registered so the read path sees a stable value
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RESET)
        begin
            ts16_all_ones_state_ff <= 1'b0;
        end
        else
        begin
            ts16_all_ones_state_ff <= I_TS16_ALL_ONES;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Enable registers; only the documented bits are stored, the rest read zero
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RESET)
        begin
            excess_zero_irq_enable_ff <= EXZ_ENABLE_RST;
            los_crc_irq_enable_ff <= LOS_CRC_ENABLE_RST;
        end
        else if (wb_wr)
        begin
            if (I_WB_ADR == EXZ_ENABLE_OFS)
            begin
                excess_zero_irq_enable_ff[NATBIT7_EN_BIT] <= I_WB_DAT[NATBIT7_EN_BIT];
                excess_zero_irq_enable_ff[EXZ_EN_BIT] <= I_WB_DAT[EXZ_EN_BIT];
            end
            if (I_WB_ADR == LOS_CRC_ENABLE_OFS)
            begin
                los_crc_irq_enable_ff[LOS_EN_BIT] <= I_WB_DAT[LOS_EN_BIT];
                los_crc_irq_enable_ff[CRC_EN_BIT] <= I_WB_DAT[CRC_EN_BIT];
            end
        end
    end

    // Polarities differ between the two enable registers: high-true here, low-true in the loss/CRC one
    assign natbit7_zero_change_irq_en = excess_zero_irq_enable_ff[NATBIT7_EN_BIT];
    assign excess_zero_change_irq_en = excess_zero_irq_enable_ff[EXZ_EN_BIT];
    assign loss_signal_change_irq_en = ~los_crc_irq_enable_ff[LOS_EN_BIT];
    assign crc_mframe_change_irq_en = ~los_crc_irq_enable_ff[CRC_EN_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Status register images
    always_comb
    begin
        excess_zero_irq_status = '0;
        excess_zero_irq_status[EXZ_FLAG_BIT] = excess_zero_change_flag_ff;
        excess_zero_irq_status[NATBIT7_FLAG_BIT] = natbit7_zero_change_flag_ff;
        excess_zero_irq_status[NATBIT7_STATE_BIT] = natbit7_zero_ff;
    end

    always_comb
    begin
        los_crc_irq_status = '0;
        los_crc_irq_status[TS16_STATE_BIT] = ts16_all_ones_state_ff;
        los_crc_irq_status[LOS_FLAG_BIT] = loss_signal_change_flag_ff;
        los_crc_irq_status[CRC_FLAG_BIT] = crc_mframe_change_flag_ff;
    end

    // Read mux; unmapped offsets answer with zero rather than an error
    always_comb
    begin
        nxt_rd_data = '0;
        case (I_WB_ADR)
            EXCESS_ZERO_CHANGE_FLAG_OFS: nxt_rd_data = {{(WB_DAT_W-REG_W){1'b0}}, excess_zero_irq_status};
            EXZ_ENABLE_OFS: nxt_rd_data = {{(WB_DAT_W-REG_W){1'b0}}, excess_zero_irq_enable_ff};
            LOS_CRC_STATUS_OFS: nxt_rd_data = {{(WB_DAT_W-REG_W){1'b0}}, los_crc_irq_status};
            LOS_CRC_ENABLE_OFS: nxt_rd_data = {{(WB_DAT_W-REG_W){1'b0}}, los_crc_irq_enable_ff};
            default: nxt_rd_data = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus answer: data is captured at the same edge that clears the read flags,
    // so the master sees the flags as they stood before the clear
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RESET)
        begin
            wb_ack_ff <= 1'b0;
            wb_dat_ff <= '0;
        end
        else
        begin
            wb_ack_ff <= wb_req;
            if (wb_rd)
            begin
                wb_dat_ff <= nxt_rd_data;
            end
        end
    end

    assign O_WB_ACK = wb_ack_ff;
    assign O_WB_DAT = wb_dat_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt request; registered, so it trails the flags by one cycle
    assign nxt_irq = (natbit7_zero_change_flag_ff & natbit7_zero_change_irq_en)
                   | (excess_zero_change_flag_ff & excess_zero_change_irq_en)
                   | (loss_signal_change_flag_ff & loss_signal_change_irq_en)
                   | (crc_mframe_change_flag_ff & crc_mframe_change_irq_en);

    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RESET)
        begin
            irq_ff <= 1'b0;
        end
        else
        begin
            irq_ff <= nxt_irq;
        end
    end

    assign O_IRQ = irq_ff;

endmodule : e1_rx_alarm_irq_logic

`default_nettype wire

// ===== bench/e1_rx_alarm_irq_logic_asserts.sv
// Checker for the receive E1 alarm interrupt block: bus handshake, interrupt timing, read data.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module e1_rx_alarm_irq_logic_chk
(
    // Clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RESET,
    // Register bus
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [e1_rx_alarm_irq_pkg::WB_ADR_W-1:0] I_WB_ADR,
    input wire logic [e1_rx_alarm_irq_pkg::WB_SEL_W-1:0] I_WB_SEL,
    input wire logic [e1_rx_alarm_irq_pkg::WB_DAT_W-1:0] I_WB_DAT,
    input wire logic [e1_rx_alarm_irq_pkg::WB_DAT_W-1:0] O_WB_DAT,
    input wire logic O_WB_ACK,
    // Alarms and interrupt
    input wire logic I_NATBIT7,
    input wire logic I_NATBIT7_VALID,
    input wire logic I_EXCESS_ZERO,
    input wire logic I_LOSS_SIGNAL,
    input wire logic I_CRC_MFRAME_LOCK,
    input wire logic I_TS16_ALL_ONES,
    input wire logic O_IRQ
);
    import e1_rx_alarm_irq_pkg::*;
    logic take;
    logic [1:0] up_ff;
    logic [1:0] exz_en_ff;
    logic [1:0] lc_en_ff;
    logic masked;
    assign take = I_WB_CYC && I_WB_STB && !O_WB_ACK;
    assign masked = (exz_en_ff == 2'h0) && (lc_en_ff == 2'h3);
    // The first sample after reset primes the detectors and makes no event
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RESET)
            up_ff <= 2'h0;
        else if (up_ff != 2'h3)
            up_ff <= up_ff + 2'h1;
    end
    // Enable mirror, loaded at the edge that takes the write
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RESET)
        begin
            exz_en_ff <= 2'h0;
            lc_en_ff <= 2'h0;
        end
        else if (take && I_WB_WE && I_WB_SEL[0])
        begin
            if (I_WB_ADR == EXZ_ENABLE_OFS)
                exz_en_ff <= I_WB_DAT[1:0];
            if (I_WB_ADR == LOS_CRC_ENABLE_OFS)
                lc_en_ff <= I_WB_DAT[3:2];
        end
    end
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RESET);
    ////////////////////////////////////////////////////////////////////////////
    chk_ack_one_cycle: assert property (take |=> O_WB_ACK ##1 !O_WB_ACK)
        else $error("ack not a single cycle after request");
    chk_ack_has_cause: assert property ($rose(O_WB_ACK) |-> $past(I_WB_CYC) && $past(I_WB_STB))
        else $error("ack without request");
    chk_reset_quiet: assert property (disable iff (1'b0) I_RESET |=> !O_IRQ && !O_WB_ACK)
        else $error("outputs active after reset edge");
    chk_dat_upper_zero: assert property (O_WB_ACK |-> O_WB_DAT[WB_DAT_W-1:REG_W] == 24'h0)
        else $error("read data upper bits set");
    chk_los_irq_raise: assert property ($changed(I_LOSS_SIGNAL) && up_ff != 2'h0 && !lc_en_ff[1]
        |-> ##[1:3] O_IRQ) else $error("loss change gave no interrupt");
    chk_crc_irq_raise: assert property ($changed(I_CRC_MFRAME_LOCK) && up_ff != 2'h0 && !lc_en_ff[0]
        |-> ##[1:3] O_IRQ) else $error("crc change gave no interrupt");
    chk_exz_irq_raise: assert property ($changed(I_EXCESS_ZERO) && up_ff != 2'h0 && exz_en_ff[0]
        |-> ##[1:3] O_IRQ) else $error("excess zero change gave no interrupt");
    chk_masked_irq_low: assert property (masked && $past(masked) |-> !O_IRQ)
        else $error("interrupt while all masked");
    chk_ts16_state_read: assert property (O_WB_ACK && !$past(I_WB_WE) && $past(I_WB_ADR) == LOS_CRC_STATUS_OFS
        && $past(I_TS16_ALL_ONES, 1) == $past(I_TS16_ALL_ONES, 2)
        && $past(I_TS16_ALL_ONES, 2) == $past(I_TS16_ALL_ONES, 3)
        |-> O_WB_DAT[TS16_STATE_BIT] == $past(I_TS16_ALL_ONES, 2)) else $error("ts16 state bit wrong");
    cov_status_read: cover property (take && !I_WB_WE && I_WB_ADR == LOS_CRC_STATUS_OFS);
    cov_enable_write: cover property (take && I_WB_WE);
    cov_irq_rise: cover property ($rose(O_IRQ));
endmodule : e1_rx_alarm_irq_logic_chk

bind e1_rx_alarm_irq_logic e1_rx_alarm_irq_logic_chk e1_rx_alarm_irq_logic_chk_i (.I_CLK_SYS, .I_RESET,
    .I_WB_CYC, .I_WB_STB, .I_WB_WE, .I_WB_ADR, .I_WB_SEL, .I_WB_DAT, .O_WB_DAT, .O_WB_ACK, .I_NATBIT7,
    .I_NATBIT7_VALID, .I_EXCESS_ZERO, .I_LOSS_SIGNAL, .I_CRC_MFRAME_LOCK, .I_TS16_ALL_ONES, .O_IRQ);
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the receive E1 alarm interrupt block.
// Assumes the checker is bound separately; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import e1_rx_alarm_irq_pkg::*;
    typedef struct packed {logic exz; logic los; logic crc; logic ts16; logic [7:0] st0; logic [7:0] st8; logic irq;} row_t;
    logic clk, rst, cyc, stb, we, ack, natbit, nvld, exz, los, crc, ts16, irq;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, junk;
    int miscompares, checked;
    // Levels applied in turn; status expected from the change since the row before
    row_t rows [6] = '{'{1, 0, 0, 0, 8'h01, 8'h00, 0}, '{1, 1, 0, 0, 8'h00, 8'h08, 1},
        '{1, 1, 1, 1, 8'h00, 8'h14, 1}, '{0, 0, 1, 1, 8'h01, 8'h18, 1},
        '{0, 0, 0, 0, 8'h00, 8'h04, 1}, '{0, 0, 0, 0, 8'h00, 8'h00, 0}};
    e1_rx_alarm_irq_logic e1_rx_alarm_irq_logic_i (.I_CLK_SYS(clk), .I_RESET(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
        .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
        .I_NATBIT7(natbit), .I_NATBIT7_VALID(nvld), .I_EXCESS_ZERO(exz), .I_LOSS_SIGNAL(los),
        .I_CRC_MFRAME_LOCK(crc), .I_TS16_ALL_ONES(ts16), .O_IRQ(irq));
    always #20 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Classic cycle; the request is held until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, w, a, d, s};
        @(posedge clk);
        while (ack !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                miscompares++;
                end_of_test();
            end
            @(posedge clk);
        end
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        bus(1'b1, a, d, s, junk);
    endtask : wr
    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hF, q);
        check(name, q, e);
    endtask : rchk
    task automatic irqchk(input logic e);
        check("irq", {31'h0, irq}, {31'h0, e});
    endtask : irqchk
    // Alarm levels change at most one edge before this and the effect lands within five edges
    task automatic settle();
        repeat (5) @(posedge clk);
    endtask : settle
    task automatic obs(input logic b);
        @(posedge clk);
        {natbit, nvld} <= {b, 1'b1};
        @(posedge clk);
        nvld <= 1'b0;
        settle();
    endtask : obs
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {clk, rst, cyc, stb, we, adr, sel, wdat} = {1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 4'h0, 32'h0};
        {natbit, nvld, exz, los, crc, ts16, miscompares, checked} = '0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk);
            {exz, los, crc, ts16} <= {rows[i].exz, rows[i].los, rows[i].crc, rows[i].ts16};
            settle();
            irqchk(rows[i].irq);
            rchk("excess_zero_change_flag", EXCESS_ZERO_CHANGE_FLAG_OFS, {24'h0, rows[i].st0});
            rchk("los_crc_status", LOS_CRC_STATUS_OFS, {24'h0, rows[i].st8});
            $display("row %0d done", i);
        end
        // Masking: flags still record while the interrupt stays low
        wr(LOS_CRC_ENABLE_OFS, 32'h0C, 4'h1);
        rchk("los_crc_enable", LOS_CRC_ENABLE_OFS, 32'h0C);
        @(posedge clk);
        {los, crc} <= 2'b11;
        settle();
        irqchk(1'b0);
        rchk("los_crc_status", LOS_CRC_STATUS_OFS, 32'h0C);
        wr(EXZ_ENABLE_OFS, 32'h01, 4'h1);
        @(posedge clk);
        exz <= 1'b1;
        settle();
        irqchk(1'b1);
        rchk("exz_enable", EXZ_ENABLE_OFS, 32'h01);
        rchk("excess_zero_change_flag", EXCESS_ZERO_CHANGE_FLAG_OFS, 32'h01);
        repeat (2) @(posedge clk);
        irqchk(1'b0);
        $display("mask test done");
        // Sa7 vote: two zeros of three declare, dropping to one zero clears
        wr(EXZ_ENABLE_OFS, 32'h02, 4'h1);
        repeat (3) obs(1'b1);
        bus(1'b0, EXCESS_ZERO_CHANGE_FLAG_OFS, 32'h0, 4'hF, junk);
        obs(1'b0);
        irqchk(1'b0);
        obs(1'b0);
        irqchk(1'b1);
        rchk("natbit7", EXCESS_ZERO_CHANGE_FLAG_OFS, 32'h22);
        obs(1'b1);
        rchk("natbit7", EXCESS_ZERO_CHANGE_FLAG_OFS, 32'h20);
        obs(1'b1);
        irqchk(1'b1);
        rchk("natbit7", EXCESS_ZERO_CHANGE_FLAG_OFS, 32'h02);
        $display("sa7 test done");
        // Lane 0 disabled write and unmapped place
        wr(EXZ_ENABLE_OFS, 32'h00, 4'h0);
        rchk("exz_enable", EXZ_ENABLE_OFS, 32'h02);
        wr(8'h10, 32'hFF, 4'hF);
        rchk("unmapped", 8'h10, 32'h0);
        // Reset in mid-run with an interrupt pending
        wr(LOS_CRC_ENABLE_OFS, 32'h00, 4'h1);
        @(posedge clk);
        los <= 1'b0;
        settle();
        irqchk(1'b1);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        irqchk(1'b0);
        rst <= 1'b0;
        rchk("exz_enable", EXZ_ENABLE_OFS, 32'h0);
        rchk("los_crc_enable", LOS_CRC_ENABLE_OFS, 32'h0);
        rchk("los_crc_status", LOS_CRC_STATUS_OFS, 32'h0);
        rchk("excess_zero_change_flag", EXCESS_ZERO_CHANGE_FLAG_OFS, 32'h0);
        $display("reset test done");
        // Event at the very edge that takes the clearing read: old value read back, flag survives
        fork
            rchk("los_crc_status", LOS_CRC_STATUS_OFS, 32'h0);
            begin
                @(posedge clk);
                los <= 1'b1;
            end
        join
        rchk("los_crc_status", LOS_CRC_STATUS_OFS, 32'h08);
        $display("set wins test done");
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
